// File: bench/serial_flash_read_path_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module serial_flash_read_path_tb_top;
	logic               i_ref_clk;
	logic               i_sys_rst;
	logic               i_start;
	sfr_pkg::sfr_kind_e i_kind;
	logic [23:0]        i_addr;
	logic [15:0]        i_len;
	logic               i_busy;
	logic               i_wr_en;
	logic [7:0]         i_wr_addr;
	logic [7:0]         i_wr_data;
	logic               o_busy;
	logic               o_rd_valid;
	logic [7:0]         o_rd_data;
	logic               o_done;
	logic               o_frame_active;
	logic [7:0]         mem [256];
	int                 err_total;
	int                 n_compared;

	// ----------------------------------------------------------
	// both ends across one link
	// ----------------------------------------------------------
	sfr_link_if link();
	sfr_flash_host #(.HALF(4)) i_sfr_flash_host (.link(link.host), .i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst), .i_start(i_start), .i_kind(i_kind), .i_addr(i_addr),
		.i_len(i_len), .o_busy(o_busy), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
		.o_done(o_done));
	sfr_flash_dev #(.ARRAY_AW(8)) i_sfr_flash_dev (.link(link.dev), .i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst), .i_busy(i_busy), .i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr),
		.i_wr_data(i_wr_data), .o_frame_active(o_frame_active));
	sfr_link_properties i_sfr_link_properties (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
		.sclk(link.sclk), .sel_n(link.sel_n), .h_out(link.h_out), .h_oe(link.h_oe),
		.d_out(link.d_out), .d_oe(link.d_oe), .io_lane(link.io_lane));

	// 10 MHz reference
	initial begin
		i_ref_clk = 1'b0;
		forever #50 i_ref_clk = ~i_ref_clk;
	end

	// ----------------------------------------------------------
	// compare and report
	// ----------------------------------------------------------
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: byte %h, expected %h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask : chk1

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: count %0d, expected %0d", $time, got, exp);
		end
	endtask : chk16

	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize

	// one read frame; entered and left at a falling edge
	task automatic rd(input sfr_pkg::sfr_kind_e k, input logic [23:0] a,
		input logic [15:0] n, input logic refuse);
		logic [15:0] got;
		logic [7:0]  idx;
		logic        seen;
		int          t;
		got = 16'h0000;
		seen = 1'b0;
		t = 0;
		chk1(o_busy, 1'b0);
		i_start = 1'b1;
		i_kind = k;
		i_addr = a;
		i_len = n;
		@(negedge i_ref_clk);
		i_start = 1'b0;
		chk1(o_busy, 1'b1);
		while (o_done !== 1'b1 && t < 40000) begin
			@(negedge i_ref_clk);
			t++;
			seen = seen | (o_frame_active === 1'b1);
			if (o_rd_valid === 1'b1) begin
				idx = a[7:0] + got[7:0];
				chk8(o_rd_data, refuse ? 8'hff : mem[idx]);
				got++;
			end
		end
		if (t >= 40000) begin
			err_total++;
			$display("Error at %0t: read never finished", $time);
			summarize();
		end
		chk16(got, n);
		chk1(seen, 1'b1);
		// frame flag needs its three sync stages before it falls
		repeat (5) @(negedge i_ref_clk);
		chk1(o_frame_active, 1'b0);
	endtask : rd

	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	sfr_pkg::sfr_kind_e kinds [5] = '{sfr_pkg::SFR_PLAIN, sfr_pkg::SFR_FAST,
		sfr_pkg::SFR_DUAL_OUT, sfr_pkg::SFR_DUAL_IO, sfr_pkg::SFR_QUAD_OUT};
	logic [23:0] addrs [5] = '{24'h000013, 24'h0000fe, 24'h7700ff, 24'h000081, 24'h0000fd};
	logic [15:0] lens [5] = '{16'h0003, 16'h0004, 16'h0003, 16'h0005, 16'h0006};

	initial begin
		i_sys_rst = 1'b1;
		i_start = 1'b0;
		i_kind = sfr_pkg::SFR_PLAIN;
		i_addr = 24'h000000;
		i_len = 16'h0000;
		i_busy = 1'b0;
		i_wr_en = 1'b0;
		i_wr_addr = 8'h00;
		i_wr_data = 8'h00;
		err_total = 0;
		n_compared = 0;
		repeat (4) @(negedge i_ref_clk);
		i_sys_rst = 1'b0;
		// rotated pattern gives every byte a distinct value
		for (int i = 0; i < 256; i++) begin
			mem[i] = {i[2:0], i[7:3]} ^ 8'ha5;
			i_wr_en = 1'b1;
			i_wr_addr = i[7:0];
			i_wr_data = mem[i];
			@(negedge i_ref_clk);
		end
		i_wr_en = 1'b0;
		@(negedge i_ref_clk);
		for (int i = 0; i < 5; i++) begin
			rd(kinds[i], addrs[i], lens[i], 1'b0);
		end
		// reads other than plain are refused while busy
		i_busy = 1'b1;
		for (int i = 1; i < 5; i++) begin
			rd(kinds[i], 24'h000010, 16'h0002, 1'b1);
		end
		rd(sfr_pkg::SFR_PLAIN, 24'h000020, 16'h0002, 1'b0);
		i_busy = 1'b0;
		rd(sfr_pkg::SFR_FAST, 24'h000040, 16'h0002, 1'b0);
		rd(sfr_pkg::SFR_DUAL_IO, 24'h0000f0, 16'h0110, 1'b0);
		rd(sfr_pkg::SFR_QUAD_OUT, 24'h0000aa, 16'h0001, 1'b0);
		rd(sfr_pkg::SFR_PLAIN, 24'h000055, 16'h0001, 1'b0);
		summarize();
	end
endmodule : serial_flash_read_path_tb_top
`default_nettype wire

// File: bench/sfr_link_properties.sv
`timescale 1ns/1ns
`default_nettype none
module sfr_link_properties (
	input wire logic       i_ref_clk,
	input wire logic       i_sys_rst,
	input wire logic       sclk,
	input wire logic       sel_n,
	input wire logic [3:0] h_out,
	input wire logic [3:0] h_oe,
	input wire logic [3:0] d_out,
	input wire logic [3:0] d_oe,
	input wire logic [3:0] io_lane
);
	// ----------------------------------------------------------
	// frame tracking in the link domain
	// ----------------------------------------------------------
	logic [15:0] n_rise;
	logic [15:0] next_n_rise;
	logic [7:0]  op;
	logic [7:0]  next_op;

	// saturate so a long stream never looks like a new command
	always_comb begin
		next_n_rise = (n_rise == 16'hffff) ? n_rise : n_rise + 16'h0001;
		next_op     = (n_rise < 16'h0008) ? {op[6:0], io_lane[0]} : op;
	end

	// select high clears, like the device itself
	always_ff @(posedge sclk or posedge sel_n) begin
		if (sel_n) begin
			n_rise <= 16'h0000;
			op     <= 8'h00;
		end else begin
			n_rise <= next_n_rise;
			op     <= next_op;
		end
	end

	// rising edges before the first data group
	function automatic logic [15:0] first_rise(input logic [7:0] c);
		if (c == sfr_pkg::SFR_OP_PLAIN) return 16'h0020;
		if (c == sfr_pkg::SFR_OP_DUAL_IO) return 16'h0018;
		return 16'h0028;
	endfunction : first_rise

	// lanes that carry data for each command
	function automatic logic [3:0] lane_pat(input logic [7:0] c);
		if (c == sfr_pkg::SFR_OP_QUAD_OUT) return 4'hf;
		if (c == sfr_pkg::SFR_OP_DUAL_OUT || c == sfr_pkg::SFR_OP_DUAL_IO) return 4'h3;
		return 4'h2;
	endfunction : lane_pat

	// ----------------------------------------------------------
	// assertions
	// ----------------------------------------------------------
	a_dev_fall_only: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(sclk && $past(sclk)) |-> ($stable(d_out) && $stable(d_oe)))
		else $error("device lanes moved while serial clock high");
	a_host_fall_only: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(sclk && $past(sclk)) |-> ($stable(h_out) && $stable(h_oe) && $stable(sel_n)))
		else $error("host lanes moved while serial clock high");
	a_release_sel: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		sel_n |-> (d_oe == 4'h0))
		else $error("device drives while deselected");
	a_no_fight: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		!sel_n |-> ((d_oe & h_oe) == 4'h0))
		else $error("host and device drive one lane");
	a_quiet_before: assert property (@(posedge sclk) disable iff (sel_n)
		(d_oe != 4'h0) |-> (n_rise >= first_rise(op)))
		else $error("device drove before data phase");
	a_data_lanes: assert property (@(posedge sclk) disable iff (sel_n)
		(d_oe != 4'h0) |-> (d_oe == lane_pat(op)))
		else $error("wrong data lanes driven");
	a_cmd_lane: assert property (@(posedge sclk) disable iff (sel_n)
		(n_rise < 16'h0008) |-> (h_oe == 4'h1))
		else $error("command not on lane zero alone");
	a_addr_lanes: assert property (@(posedge sclk) disable iff (sel_n)
		(n_rise >= 16'h0008 && n_rise < ((op == sfr_pkg::SFR_OP_DUAL_IO) ? 16'h0014 : 16'h0020))
		|-> (h_oe == ((op == sfr_pkg::SFR_OP_DUAL_IO) ? 4'h3 : 4'h1)))
		else $error("address on wrong lanes");
endmodule : sfr_link_properties
`default_nettype wire

// File: common/sfr_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sfr_link_if;
	logic       sclk;
	logic       sel_n;
	logic [3:0] h_out;
	logic [3:0] h_oe;
	logic [3:0] d_out;
	logic [3:0] d_oe;
	logic [3:0] io_lane;

	// wire level: device first, then host, else the pull-up
	assign io_lane = (d_oe & d_out) | (~d_oe & h_oe & h_out) | (~d_oe & ~h_oe);

	modport host (
		output sclk,
		output sel_n,
		output h_out,
		output h_oe,
		input  io_lane
	);

	modport dev (
		input  sclk,
		input  sel_n,
		input  io_lane,
		output d_out,
		output d_oe
	);
endinterface : sfr_link_if
`default_nettype wire

// File: common/sfr_pkg.sv
`default_nettype none
package sfr_pkg;

	// --------------------------------------------------------------
	// frame layout
	// --------------------------------------------------------------
	localparam int         SFR_ADDR_BITS   = 24;
	localparam logic [4:0] SFR_CMD_LAST    = 5'h07;
	localparam logic [4:0] SFR_ADDR_LAST_1 = 5'h17;
	localparam logic [4:0] SFR_ADDR_LAST_2 = 5'h0b;
	localparam logic [4:0] SFR_DUMMY_STD   = 5'h08;
	localparam logic [4:0] SFR_DUMMY_DIO   = 5'h04;
	localparam int         SFR_HALF_DIV    = 4;

	// --------------------------------------------------------------
	// command codes
	// --------------------------------------------------------------
	localparam logic [7:0] SFR_OP_PLAIN    = 8'h03;
	localparam logic [7:0] SFR_OP_FAST     = 8'h0b;
	localparam logic [7:0] SFR_OP_DUAL_OUT = 8'h3b;
	localparam logic [7:0] SFR_OP_DUAL_IO  = 8'hbb;
	localparam logic [7:0] SFR_OP_QUAD_OUT = 8'h6b;

	// output enable patterns, bit n is io_lane n
	localparam logic [3:0] SFR_OE_NONE = 4'h0;
	localparam logic [3:0] SFR_OE_SI   = 4'h1;
	localparam logic [3:0] SFR_OE_SO   = 4'h2;
	localparam logic [3:0] SFR_OE_DUAL = 4'h3;
	localparam logic [3:0] SFR_OE_QUAD = 4'hf;

	typedef enum logic [2:0] {
		SFR_PLAIN    = 3'b000,
		SFR_FAST     = 3'b001,
		SFR_DUAL_OUT = 3'b010,
		SFR_DUAL_IO  = 3'b011,
		SFR_QUAD_OUT = 3'b100
	} sfr_kind_e;

	// opcode sent for each read kind
	function automatic logic [7:0] sfr_opcode(input sfr_kind_e k);
		case (k)
			SFR_FAST:     return SFR_OP_FAST;
			SFR_DUAL_OUT: return SFR_OP_DUAL_OUT;
			SFR_DUAL_IO:  return SFR_OP_DUAL_IO;
			SFR_QUAD_OUT: return SFR_OP_QUAD_OUT;
			default:      return SFR_OP_PLAIN;
		endcase
	endfunction : sfr_opcode

	// dummy clocks before data
	function automatic logic [4:0] sfr_dummy(input sfr_kind_e k);
		case (k)
			SFR_PLAIN:   return 5'h00;
			SFR_DUAL_IO: return SFR_DUMMY_DIO;
			default:     return SFR_DUMMY_STD;
		endcase
	endfunction : sfr_dummy

	// log2 of data lanes
	function automatic logic [1:0] sfr_lane_log2(input sfr_kind_e k);
		case (k)
			SFR_DUAL_OUT, SFR_DUAL_IO: return 2'h1;
			SFR_QUAD_OUT:              return 2'h2;
			default:                   return 2'h0;
		endcase
	endfunction : sfr_lane_log2

endpackage : sfr_pkg
`default_nettype wire

// File: rtl/sfr_flash_dev.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - sample on rising, drive on falling edge
// - start address may be any byte
// - address advances after every byte out
// - address wraps to zero past the top
// - plain read: command, address, data, no dummy
// - select high ends frame, outputs released
// - fast read: address, eight dummy, single data
// - multi-lane and fast reads refused while busy
// - dual output: lane 0 in, two-lane data
// - dual io: two-lane address, four dummy
// - quad output: single address, four-lane data
module sfr_flash_dev #(
	parameter int ARRAY_AW = 8
) (
	sfr_link_if.dev                  link,
	input  wire logic                i_ref_clk,
	input  wire logic                i_sys_rst,
	input  wire logic                i_busy,
	input  wire logic                i_wr_en,
	input  wire logic [ARRAY_AW-1:0] i_wr_addr,
	input  wire logic [7:0]          i_wr_data,
	output logic                     o_frame_active
);

	typedef enum logic [2:0] {
		SFR_D_CMD    = 3'b000,
		SFR_D_ADDR   = 3'b001,
		SFR_D_DUMMY  = 3'b010,
		SFR_D_DATA   = 3'b011,
		SFR_D_IGNORE = 3'b100
	} sfr_dev_state_e;

	// --------------------------------------------------------------
	// array, written from the system clock
	// --------------------------------------------------------------
	logic [7:0] mem [2**ARRAY_AW];

	// reads see the cell asynchronously; load only between frames
	for (genvar g = 0; g < 2**ARRAY_AW; g++) begin : g_cell
		always_ff @(posedge i_ref_clk) begin
			if (i_wr_en && i_wr_addr == ARRAY_AW'(g)) begin
				mem[g] <= i_wr_data;
			end
		end
	end

	// --------------------------------------------------------------
	// frame status toward the system clock
	// --------------------------------------------------------------
	logic f1;
	logic f2;
	logic f3;
	logic frame;
	logic next_frame;

	// change counts once the last two stages agree
	always_comb begin
		next_frame = (f2 == f3) ? f3 : frame;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			f1    <= 1'b0;
			f2    <= 1'b0;
			f3    <= 1'b0;
			frame <= 1'b0;
		end else begin
			f1    <= ~link.sel_n;
			f2    <= f1;
			f3    <= f2;
			frame <= next_frame;
		end
	end

	assign o_frame_active = frame;

	// --------------------------------------------------------------
	// rising-edge side: command, address, dummy, data count
	// --------------------------------------------------------------
	sfr_dev_state_e      state;
	sfr_dev_state_e      next_state;
	logic [4:0]          cnt;
	logic [4:0]          next_cnt;
	logic [23:0]         sh;
	logic [23:0]         next_sh;
	sfr_pkg::sfr_kind_e  kind;
	sfr_pkg::sfr_kind_e  next_kind;
	logic [ARRAY_AW-1:0] addr;
	logic [ARRAY_AW-1:0] next_addr;
	logic                b1;
	logic                b2;
	logic                b3;
	logic                busy;
	logic                next_busy;
	logic [7:0]          op_in;
	logic [23:0]         full_addr;
	logic [1:0]          lw;
	logic                dual_io;

	assign op_in     = {sh[6:0], link.io_lane[0]};
	assign dual_io   = (kind == sfr_pkg::SFR_DUAL_IO);
	assign lw        = sfr_pkg::sfr_lane_log2(kind);
	// last address group taken straight from the pins
	assign full_addr = dual_io ? {sh[21:0], link.io_lane[1:0]}
	                           : {sh[22:0], link.io_lane[0]};

	always_comb begin
		next_state = state;
		next_cnt   = cnt + 5'h01;
		next_sh    = {sh[22:0], link.io_lane[0]};
		next_kind  = kind;
		next_addr  = addr;
		next_busy  = (b2 == b3) ? b3 : busy;
		case (state)
			SFR_D_CMD: begin
				if (cnt == sfr_pkg::SFR_CMD_LAST) begin
					next_cnt   = 5'h00;
					next_state = SFR_D_ADDR;
					if (op_in == sfr_pkg::SFR_OP_PLAIN) begin
						next_kind = sfr_pkg::SFR_PLAIN;
					end else if (op_in == sfr_pkg::SFR_OP_FAST) begin
						next_kind = sfr_pkg::SFR_FAST;
					end else if (op_in == sfr_pkg::SFR_OP_DUAL_OUT) begin
						next_kind = sfr_pkg::SFR_DUAL_OUT;
					end else if (op_in == sfr_pkg::SFR_OP_DUAL_IO) begin
						next_kind = sfr_pkg::SFR_DUAL_IO;
					end else if (op_in == sfr_pkg::SFR_OP_QUAD_OUT) begin
						next_kind = sfr_pkg::SFR_QUAD_OUT;
					end else begin
						next_state = SFR_D_IGNORE; // unknown code: stay silent
					end
					// plain read still allowed during internal cycles
					if (busy && op_in != sfr_pkg::SFR_OP_PLAIN) begin
						next_state = SFR_D_IGNORE;
					end
				end
			end
			SFR_D_ADDR: begin
				if (dual_io) begin
					next_sh = {sh[21:0], link.io_lane[1:0]};
				end
				if (cnt == (dual_io ? sfr_pkg::SFR_ADDR_LAST_2
				                    : sfr_pkg::SFR_ADDR_LAST_1)) begin
					next_cnt  = 5'h00;
					next_addr = full_addr[ARRAY_AW-1:0];
					if (kind == sfr_pkg::SFR_PLAIN) begin
						next_state = SFR_D_DATA;
					end else begin
						next_state = SFR_D_DUMMY;
					end
				end
			end
			SFR_D_DUMMY: begin
				next_sh = sh;
				// dummy lengths per kind: 8 or 4 clocks
				if (cnt == sfr_pkg::sfr_dummy(kind) - 5'h01) begin
					next_cnt   = 5'h00;
					next_state = SFR_D_DATA;
				end
			end
			SFR_D_DATA: begin
				next_sh = sh;
				// groups per byte: 8, 4 or 2
				if (cnt[2:0] == (3'h7 >> lw)) begin
					next_cnt  = 5'h00;
					next_addr = addr + 1'b1;
				end
			end
			default: begin
				next_sh  = sh;
				next_cnt = cnt;
			end
		endcase
	end

	// select high clears the frame even with the clock stopped
	always_ff @(posedge link.sclk or posedge link.sel_n) begin
		if (link.sel_n) begin
			state <= SFR_D_CMD;
			cnt   <= 5'h00;
			sh    <= 24'h000000;
			kind  <= sfr_pkg::SFR_PLAIN;
			addr  <= '0;
			b1    <= 1'b0;
			b2    <= 1'b0;
			b3    <= 1'b0;
			busy  <= 1'b0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
			sh    <= next_sh;
			kind  <= next_kind;
			addr  <= next_addr;
			b1    <= i_busy;
			b2    <= b1;
			b3    <= b2;
			busy  <= next_busy;
		end
	end

	// --------------------------------------------------------------
	// falling-edge side: output lanes
	// --------------------------------------------------------------
	logic [3:0] out_q;
	logic [3:0] next_out;
	logic [3:0] oe_q;
	logic [3:0] next_oe;
	logic [7:0] byte_sh;
	logic [2:0] shamt;

	// group index scaled to a bit offset inside the byte
	always_comb begin
		case (lw)
			2'h1:    shamt = {cnt[1:0], 1'b0};
			2'h2:    shamt = {cnt[0], 2'b00};
			default: shamt = cnt[2:0];
		endcase
		byte_sh = 8'(mem[addr] << shamt);
	end

	always_comb begin
		next_out = 4'h0;
		next_oe  = sfr_pkg::SFR_OE_NONE;
		if (state == SFR_D_DATA) begin
			case (lw)
				2'h1: begin
					next_out = {2'b00, byte_sh[7:6]};
					next_oe  = sfr_pkg::SFR_OE_DUAL;
				end
				2'h2: begin
					next_out = byte_sh[7:4];
					next_oe  = sfr_pkg::SFR_OE_QUAD;
				end
				default: begin
					next_out = {2'b00, byte_sh[7], 1'b0};
					next_oe  = sfr_pkg::SFR_OE_SO;
				end
			endcase
		end
	end

	always_ff @(negedge link.sclk or posedge link.sel_n) begin
		if (link.sel_n) begin
			out_q <= 4'h0;
			oe_q  <= sfr_pkg::SFR_OE_NONE;
		end else begin
			out_q <= next_out;
			oe_q  <= next_oe;
		end
	end

	assign link.d_out = out_q;
	assign link.d_oe  = oe_q;

endmodule : sfr_flash_dev
`default_nettype wire

// File: rtl/sfr_flash_host.sv
`timescale 1ns/1ns
`default_nettype none
module sfr_flash_host #(
	parameter int HALF = sfr_pkg::SFR_HALF_DIV
) (
	sfr_link_if.host                 link,
	input  wire logic                i_ref_clk,
	input  wire logic                i_sys_rst,
	input  wire logic                i_start,
	input  wire sfr_pkg::sfr_kind_e  i_kind,
	input  wire logic [23:0]         i_addr,
	input  wire logic [15:0]         i_len,
	output logic                     o_busy,
	output logic                     o_rd_valid,
	output logic [7:0]               o_rd_data,
	output logic                     o_done
);

	localparam int DW = $clog2(2 * HALF);

	typedef enum logic [2:0] {
		SFR_H_IDLE  = 3'b000,
		SFR_H_CMD   = 3'b001,
		SFR_H_ADDR  = 3'b010,
		SFR_H_DUMMY = 3'b011,
		SFR_H_DATA  = 3'b100,
		SFR_H_END   = 3'b101
	} sfr_host_state_e;

	// --------------------------------------------------------------
	// lane input filter
	// --------------------------------------------------------------
	logic [3:0] s1;
	logic [3:0] s2;
	logic [3:0] s3;
	logic [3:0] filt;
	logic [3:0] next_filt;

	always_comb begin
		next_filt = (s2 == s3) ? s3 : filt;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			s1   <= 4'hf;
			s2   <= 4'hf;
			s3   <= 4'hf;
			filt <= 4'hf;
		end else begin
			s1   <= link.io_lane;
			s2   <= s1;
			s3   <= s2;
			filt <= next_filt;
		end
	end

	// --------------------------------------------------------------
	// frame sequencer and clock divider
	// --------------------------------------------------------------
	sfr_host_state_e    state, next_state;
	sfr_pkg::sfr_kind_e kind, next_kind;
	logic [DW-1:0]      div, next_div;
	logic               sclk, next_sclk;
	logic               sel_n, next_sel_n;
	logic [3:0]         hout, next_hout;
	logic [3:0]         hoe, next_hoe;
	logic [31:0]        sh, next_sh;
	logic [4:0]         cnt, next_cnt;
	logic [15:0]        len, next_len;
	logic [7:0]         rx, next_rx;
	logic               rd_valid, next_rd_valid;
	logic [7:0]         rd_data, next_rd_data;
	logic               done, next_done;
	logic               busy, next_busy;
	logic               tick;
	logic               dio;
	logic [1:0]         lw;

	// tick: last system cycle of the high half, just before the fall
	assign tick = (div == DW'(2 * HALF - 1));
	assign dio  = (kind == sfr_pkg::SFR_DUAL_IO);
	assign lw   = sfr_pkg::sfr_lane_log2(kind);

	always_comb begin
		next_state    = state;
		next_kind     = kind;
		next_div      = tick ? '0 : div + 1'b1;
		next_sclk     = sclk;
		next_sel_n    = sel_n;
		next_sh       = sh;
		next_cnt      = cnt;
		next_len      = len;
		next_rx       = rx;
		next_rd_valid = 1'b0;
		next_rd_data  = rd_data;
		next_done     = 1'b0;
		if (div == DW'(HALF - 1)) begin
			next_sclk = 1'b1;
		end
		if (tick) begin
			next_sclk = 1'b0;
			next_cnt  = cnt + 5'h01;
		end
		case (state)
			SFR_H_IDLE: begin
				next_div  = '0;
				next_sclk = 1'b0;
				next_cnt  = 5'h00;
				if (i_start) begin
					next_sel_n = 1'b0;
					next_kind  = i_kind;
					next_sh    = {sfr_pkg::sfr_opcode(i_kind), i_addr};
					next_len   = i_len;
					next_state = SFR_H_CMD;
				end
			end
			SFR_H_CMD: begin
				if (tick) begin
					next_sh = {sh[30:0], 1'b0};
					if (cnt == sfr_pkg::SFR_CMD_LAST) begin
						next_cnt   = 5'h00;
						next_state = SFR_H_ADDR;
					end
				end
			end
			SFR_H_ADDR: begin
				if (tick) begin
					next_sh = dio ? {sh[29:0], 2'b00} : {sh[30:0], 1'b0};
					if (cnt == (dio ? sfr_pkg::SFR_ADDR_LAST_2
					                : sfr_pkg::SFR_ADDR_LAST_1)) begin
						next_cnt = 5'h00;
						if (kind == sfr_pkg::SFR_PLAIN) begin
							next_state = SFR_H_DATA;
						end else begin
							next_state = SFR_H_DUMMY;
						end
					end
				end
			end
			SFR_H_DUMMY: begin
				if (tick && cnt == sfr_pkg::sfr_dummy(kind) - 5'h01) begin
					next_cnt   = 5'h00;
					next_state = SFR_H_DATA;
				end
			end
			SFR_H_DATA: begin
				if (tick) begin
					case (lw)
						2'h1:    next_rx = {rx[5:0], filt[1:0]};
						2'h2:    next_rx = {rx[3:0], filt};
						default: next_rx = {rx[6:0], filt[1]};
					endcase
					if (cnt[2:0] == (3'h7 >> lw)) begin
						next_cnt      = 5'h00;
						next_rd_valid = 1'b1;
						next_rd_data  = next_rx;
						next_len      = len - 16'h0001;
						if (len == 16'h0001) begin
							next_state = SFR_H_END;
						end
					end
				end
			end
			default: begin
				next_sel_n = 1'b1;
				next_sclk  = 1'b0;
				next_div   = '0;
				next_done  = 1'b1;
				next_state = SFR_H_IDLE;
			end
		endcase
		// lanes driven only in command and address phases
		next_hout = 4'h0;
		next_hoe  = sfr_pkg::SFR_OE_NONE;
		if (next_state == SFR_H_ADDR && next_kind == sfr_pkg::SFR_DUAL_IO) begin
			next_hout = {2'b00, next_sh[31:30]};
			next_hoe  = sfr_pkg::SFR_OE_DUAL;
		end else if (next_state == SFR_H_CMD || next_state == SFR_H_ADDR) begin
			next_hout = {3'b000, next_sh[31]};
			next_hoe  = sfr_pkg::SFR_OE_SI;
		end
		next_busy = (next_state != SFR_H_IDLE);
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state    <= SFR_H_IDLE;
			kind     <= sfr_pkg::SFR_PLAIN;
			div      <= '0;
			sclk     <= 1'b0;
			sel_n    <= 1'b1;
			hout     <= 4'h0;
			hoe      <= sfr_pkg::SFR_OE_NONE;
			sh       <= 32'h00000000;
			cnt      <= 5'h00;
			len      <= 16'h0000;
			rx       <= 8'h00;
			rd_valid <= 1'b0;
			rd_data  <= 8'h00;
			done     <= 1'b0;
			busy     <= 1'b0;
		end else begin
			state    <= next_state;
			kind     <= next_kind;
			div      <= next_div;
			sclk     <= next_sclk;
			sel_n    <= next_sel_n;
			hout     <= next_hout;
			hoe      <= next_hoe;
			sh       <= next_sh;
			cnt      <= next_cnt;
			len      <= next_len;
			rx       <= next_rx;
			rd_valid <= next_rd_valid;
			rd_data  <= next_rd_data;
			done     <= next_done;
			busy     <= next_busy;
		end
	end

	assign link.sclk  = sclk;
	assign link.sel_n = sel_n;
	assign link.h_out = hout;
	assign link.h_oe  = hoe;
	assign o_busy     = busy;
	assign o_rd_valid = rd_valid;
	assign o_rd_data  = rd_data;
	assign o_done     = done;

endmodule : sfr_flash_host
`default_nettype wire
